// ### eil_pkg.sv
// Shared constants and types for the external interrupt latch block
package eil_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int EIL_ADDR_W = 16;
   localparam int EIL_DATA_W = 32;
   // Printed offset is not word aligned, so it is kept as an index
   localparam logic [EIL_ADDR_W-1:0] EIL_STATUS_CONTROL_IDX = 16'h001A;
   localparam logic [EIL_ADDR_W-1:0] EIL_STATUS_CONTROL_ADDR = 16'h0068;
   localparam logic [7:0] EIL_STATUS_CONTROL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int EIL_BIT_MODE = 0;
   localparam int EIL_BIT_MASK = 1;
   localparam int EIL_BIT_ACK = 2;
   localparam int EIL_BIT_FLAG = 3;

   // ----------------------------------------------------------------
   // Pin and reset values
   // ----------------------------------------------------------------
   localparam logic EIL_PIN_IDLE = 1'b1;
   localparam logic EIL_MODE_RESET = 1'b0;
   localparam logic EIL_MASK_RESET = 1'b0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [EIL_ADDR_W-1:0] paddr;
      logic [EIL_DATA_W-1:0] pwdata;
   } eil_apb_req_t;

   typedef struct packed {
      logic mask;
      logic mode;
   } eil_ctrl_t;

   typedef enum logic [1:0] {
      EIL_IDLE = 2'b00,
      EIL_PEND = 2'b01,
      EIL_PEND_ACKED = 2'b10
   } eil_state_t;

endpackage

// ### eil_pin_sync.sv
// Two-flop synchroniser for the external interrupt pin
`timescale 1ns/1ns
`default_nettype none
module eil_pin_sync
   import eil_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Pin
   input wire logic pin_in,
   output logic pin_sync_out
);

   logic meta_reg;

   // Only the second flop reads the first one
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         // Reset to the asserted level: a pin held low through reset gives no false edge
         meta_reg <= !EIL_PIN_IDLE;
         pin_sync_out <= !EIL_PIN_IDLE;
      end else begin
         meta_reg <= pin_in;
         pin_sync_out <= meta_reg;
      end
   end

endmodule
`default_nettype wire

// ### eil_apb_slave.sv
// APB slave front end for the single status/control register
`timescale 1ns/1ns
`default_nettype none
module eil_apb_slave
   import eil_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Bus
   input wire eil_apb_req_t apb_req_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic [EIL_DATA_W-1:0] prdata_out,
   // Register side
   input wire logic [7:0] reg_image_in,
   output logic wr_pulse_out,
   output logic [7:0] wr_data_out
);

   logic hit;
   logic setup;
   logic access;

   assign hit = (apb_req_in.paddr == EIL_STATUS_CONTROL_ADDR);
   assign setup = apb_req_in.psel && !apb_req_in.penable;
   assign access = apb_req_in.psel && apb_req_in.penable;

   // Zero wait states: every access completes on its first access cycle
   assign pready_out = access;
   assign pslverr_out = access && !hit;
   assign wr_pulse_out = access && apb_req_in.pwrite && hit;
   assign wr_data_out = apb_req_in.pwdata[7:0];

   // Read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         prdata_out <= '0;
      end else if (setup) begin
         if (hit && !apb_req_in.pwrite) begin
            prdata_out <= {24'h000000, reg_image_in};
         end else begin
            prdata_out <= '0;
         end
      end
   end

endmodule
`default_nettype wire

// ### eil_latch.sv
// External interrupt latch: pin detection, latch, mask and status register
//
// Notes on behaviour
// - A falling pin edge sets the latch in either sensitivity setting.
// - A CPU vector fetch of this block's vector acknowledges and clears the latch.
// - Writing one to the acknowledge bit clears the latch, subject to break gating.
// - Reset clears the latch and sensitivity bit, even with the pin held low.
// - Edge-only sensitivity: acknowledge clears the latch at once, whatever the pin.
// - Edge-and-level: clear needs both acknowledge and pin high, in either order.
// - Edge-and-level: the request stays pending while the pin is low.
// - The request reaches the CPU only while mask is clear; mask keeps the latch.
// - Acknowledge does not block detection; a later falling edge latches again.
// - Pending flag at bit 3 reads the latch state; writes to it are ignored.
// - Pending flag shows the latch regardless of the mask bit.
// - Acknowledge bit 2 is write-only and always reads zero.
// - Mask bit 1 is read/write, one disables requests, reset clears it.
// - Sensitivity bit 0 is read/write, one adds low levels, reset clears it.
// - In break with break clear disabled, software acknowledge leaves the latch alone.
// - In break with break clear enabled, software acknowledge clears and it stays clear.
// - Register sits at offset 1A, bits 7 to 4 read zero, all reset to zero.
`timescale 1ns/1ns
`default_nettype none
module eil_latch
   import eil_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // APB register bus
   input wire eil_apb_req_t apb_req_in,
   output logic pready_out,
   output logic pslverr_out,
   output logic [EIL_DATA_W-1:0] prdata_out,
   // External interrupt pin, active low
   input wire logic irq_pin_n_in,
   // CPU interface
   input wire logic vector_fetch_in,
   output logic irq_request_out,
   output logic vector_ack_out,
   // System integration
   input wire logic break_state_in,
   input wire logic break_clear_enable_in
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic pin_sync;
   logic pin_prev_reg;
   logic fall_det;
   logic pin_low;
   logic wr_pulse;
   logic [7:0] wr_data;
   logic [7:0] reg_image;
   eil_ctrl_t ctrl_reg;
   eil_state_t state_reg;
   eil_state_t state_next;
   logic latch;
   logic sw_ack;
   logic ack_any;

   // Builds the register image as software sees it
   function automatic logic [7:0] status_image(input logic pend, input eil_ctrl_t c);
      logic [7:0] img;
      img = EIL_STATUS_CONTROL_RESET;
      img[EIL_BIT_FLAG] = pend;
      img[EIL_BIT_MASK] = c.mask;
      img[EIL_BIT_MODE] = c.mode;
      return img;
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisation and detection
   // ----------------------------------------------------------------
   eil_pin_sync u_pin_sync (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .pin_in(irq_pin_n_in),
      .pin_sync_out(pin_sync)
   );

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         // Matches the synchroniser's reset level, so only a later high-to-low counts
         pin_prev_reg <= !EIL_PIN_IDLE;
      end else begin
         pin_prev_reg <= pin_sync;
      end
   end

   assign fall_det = pin_prev_reg && !pin_sync;
   assign pin_low = !pin_sync;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   eil_apb_slave u_apb (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .apb_req_in(apb_req_in),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .prdata_out(prdata_out),
      .reg_image_in(reg_image),
      .wr_pulse_out(wr_pulse),
      .wr_data_out(wr_data)
   );

   // Flag shows the latch, never the masked request
   assign reg_image = status_image(latch, ctrl_reg);

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         ctrl_reg.mask <= EIL_MASK_RESET;
         ctrl_reg.mode <= EIL_MODE_RESET;
      end else if (wr_pulse) begin
         ctrl_reg.mask <= wr_data[EIL_BIT_MASK];
         ctrl_reg.mode <= wr_data[EIL_BIT_MODE];
      end
   end

   // ----------------------------------------------------------------
   // Acknowledge sources
   // ----------------------------------------------------------------
   // Break protection keeps a debugger from losing a pending request
   assign sw_ack = wr_pulse && wr_data[EIL_BIT_ACK]
      && !(break_state_in && !break_clear_enable_in);
   assign ack_any = sw_ack || (vector_fetch_in && latch);

   // ----------------------------------------------------------------
   // Latch state machine
   // ----------------------------------------------------------------
   // A new edge always wins over a simultaneous acknowledge
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         EIL_IDLE: begin
            if (fall_det) begin
               state_next = EIL_PEND;
            end
         end
         EIL_PEND: begin
            if (fall_det) begin
               state_next = EIL_PEND;
            end else if (ack_any) begin
               if (!ctrl_reg.mode || !pin_low) begin
                  state_next = EIL_IDLE;
               end else begin
                  state_next = EIL_PEND_ACKED;
               end
            end
         end
         EIL_PEND_ACKED: begin
            if (fall_det) begin
               state_next = EIL_PEND;
            end else if (!ctrl_reg.mode || !pin_low) begin
               state_next = EIL_IDLE;
            end
         end
         default: begin
            state_next = EIL_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         state_reg <= EIL_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign latch = (state_reg != EIL_IDLE);

   // ----------------------------------------------------------------
   // CPU outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         vector_ack_out <= 1'b0;
      end else begin
         vector_ack_out <= vector_fetch_in && latch;
      end
   end

   // Combinational so the priority logic sees a mask change at once
   assign irq_request_out = latch && !ctrl_reg.mask;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!reset_n_in);

   chk_fall_sets_latch: assert property (
      fall_det |=> latch ##0 irq_request_out == !ctrl_reg.mask)
      else $error("falling edge did not set the latch");

   chk_edge_ack_clear: assert property (
      latch && !ctrl_reg.mode && ack_any && !fall_det |=> !latch)
      else $error("edge mode acknowledge did not clear the latch");

   chk_level_hold_low: assert property (
      latch && ctrl_reg.mode && pin_low |=> latch)
      else $error("latch dropped while pin held low in level mode");

   chk_level_both_clear: assert property (
      state_reg == EIL_PEND_ACKED && ctrl_reg.mode && !pin_low && !fall_det |=> !latch)
      else $error("level mode did not clear after ack and pin high");

   chk_mask_gates_req: assert property (
      ctrl_reg.mask && latch |-> !irq_request_out)
      else $error("masked request reached the cpu");

   chk_mask_keeps_latch: assert property (
      ctrl_reg.mask && state_reg == EIL_PEND && !ack_any |=> latch)
      else $error("mask bit altered the latch");

   chk_flag_readback: assert property (
      apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite
      && apb_req_in.paddr == EIL_STATUS_CONTROL_ADDR
      |=> prdata_out[EIL_BIT_FLAG] == $past(latch) && prdata_out[7:4] == 4'h0)
      else $error("pending flag read back wrong");

   chk_ack_reads_zero: assert property (
      pready_out |-> prdata_out[EIL_BIT_ACK] == 1'b0)
      else $error("acknowledge bit read as one");

   chk_break_protect: assert property (
      state_reg == EIL_PEND && break_state_in && !break_clear_enable_in && !vector_fetch_in
      && wr_pulse |=> latch)
      else $error("software ack cleared latch during protected break");

   chk_ctrl_write: assert property (
      wr_pulse |=> ctrl_reg.mask == $past(wr_data[EIL_BIT_MASK])
      && ctrl_reg.mode == $past(wr_data[EIL_BIT_MODE]))
      else $error("control bits not written");

   chk_reset_clear: assert property (
      disable iff (1'b0) !reset_n_in |=> !latch && !ctrl_reg.mode && !ctrl_reg.mask)
      else $error("reset did not clear latch and control");

   // ----------------------------------------------------------------
   // Checks on the CPU side
   // ----------------------------------------------------------------
   chk_mask_forwards: assert property (
      latch && !ctrl_reg.mask |-> irq_request_out)
      else $error("unmasked request not forwarded");

   chk_vack_pulse: assert property (
      vector_fetch_in && latch |=> vector_ack_out)
      else $error("vector fetch gave no acknowledge");

   chk_vack_cause: assert property (
      vector_ack_out |-> $past(vector_fetch_in) && $past(latch))
      else $error("acknowledge without a vector fetch");

   chk_vack_one_cycle: assert property (
      vector_ack_out && !vector_fetch_in |=> !vector_ack_out)
      else $error("acknowledge stood too long");

   chk_fetch_edge_clear: assert property (
      latch && !ctrl_reg.mode && vector_fetch_in && !fall_det
      |=> !latch && !irq_request_out)
      else $error("edge mode vector fetch did not clear the latch");

   chk_level_fetch_hold: assert property (
      state_reg == EIL_PEND && ctrl_reg.mode && pin_low && vector_fetch_in && !fall_det
      |=> state_reg == EIL_PEND_ACKED && latch)
      else $error("level mode fetch dropped a low request");

   // ----------------------------------------------------------------
   // Checks on the latch
   // ----------------------------------------------------------------
   chk_edge_wins: assert property (
      fall_det && ack_any |=> latch)
      else $error("acknowledge beat a new falling edge");

   chk_no_spurious_set: assert property (
      !latch && !fall_det |=> !latch)
      else $error("latch set without a falling edge");

   chk_state_legal: assert property (
      state_reg inside {EIL_IDLE, EIL_PEND, EIL_PEND_ACKED})
      else $error("latch state left its legal codes");

   chk_sync_delay: assert property (
      $fell(pin_sync) |-> $past(irq_pin_n_in, 2) == 1'b0)
      else $error("synchronised pin fell without the pin");

   chk_level_needs_ack: assert property (
      state_reg == EIL_PEND && ctrl_reg.mode && !ack_any |=> latch)
      else $error("level mode cleared without an acknowledge");

   chk_mode_clear_acked: assert property (
      state_reg == EIL_PEND_ACKED && !ctrl_reg.mode && !fall_det |=> !latch)
      else $error("acked request stayed set in edge mode");

   chk_sw_edge_clear: assert property (
      state_reg == EIL_PEND && !ctrl_reg.mode && wr_pulse && wr_data[EIL_BIT_ACK]
      && !break_state_in && !fall_det |=> !latch)
      else $error("software acknowledge did not clear the latch");

   chk_break_clear_ok: assert property (
      state_reg == EIL_PEND && !ctrl_reg.mode && wr_pulse && wr_data[EIL_BIT_ACK]
      && break_state_in && break_clear_enable_in && !fall_det |=> !latch)
      else $error("enabled break clear left the latch set");

   // ----------------------------------------------------------------
   // Checks on the register
   // ----------------------------------------------------------------
   chk_image_flag: assert property (
      reg_image[EIL_BIT_FLAG] == latch)
      else $error("pending flag differs from the latch");

   chk_image_fixed_zero: assert property (
      reg_image[EIL_BIT_ACK] == 1'b0 && reg_image[7:4] == 4'h0)
      else $error("fixed zero bits read as one");

   chk_flag_write_ignored: assert property (
      state_reg == EIL_PEND && wr_pulse && !wr_data[EIL_BIT_ACK] && !vector_fetch_in
      |=> latch)
      else $error("write without ack changed the latch");

   chk_ctrl_hold: assert property (
      !wr_pulse |=> $stable(ctrl_reg))
      else $error("control bits changed without a write");

   chk_unmapped_error: assert property (
      apb_req_in.psel && apb_req_in.penable && apb_req_in.paddr != EIL_STATUS_CONTROL_ADDR
      |-> pslverr_out && !wr_pulse)
      else $error("unmapped access not refused");

   chk_zero_wait: assert property (
      apb_req_in.psel && apb_req_in.penable |-> pready_out)
      else $error("register access was stalled");

   chk_unmapped_reads_zero: assert property (
      apb_req_in.psel && !apb_req_in.penable && apb_req_in.paddr != EIL_STATUS_CONTROL_ADDR
      |=> prdata_out == '0)
      else $error("unmapped read returned data");

endmodule
`default_nettype wire

// ### eil_irq_source.sv
// Behavioural model of the external source that drives the interrupt pin
`timescale 1ns/1ns
`default_nettype none
module eil_irq_source (
   // Clock
   input wire logic clk_sys_in,
   // Command from the bench
   input wire logic assert_in,
   // Pin, active low
   output logic irq_pin_n_out
);
   // Registered so every level lasts at least one whole cycle
   always_ff @(posedge clk_sys_in) begin
      irq_pin_n_out <= !assert_in;
   end
endmodule
`default_nettype wire

// ### test_eil_latch.sv
// Self-checking testbench for the external interrupt latch
`timescale 1ns/1ns
`default_nettype none
module test_eil_latch
   import eil_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic reset_n_in = 1'b0;
   eil_apb_req_t req = '0;
   logic pready, pslverr, irq_req, vack, irq_pin_n;
   logic [EIL_DATA_W-1:0] prdata;
   logic vfetch = 1'b0;
   logic brk = 1'b0;
   logic bce = 1'b0;
   logic low = 1'b0;
   int miscompares = 0;
   int n_compared = 0;
   logic [31:0] exp_q[$];

   eil_latch i_eil_latch (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .apb_req_in(req),
      .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
      .irq_pin_n_in(irq_pin_n), .vector_fetch_in(vfetch), .irq_request_out(irq_req),
      .vector_ack_out(vack), .break_state_in(brk), .break_clear_enable_in(bce));
   eil_irq_source i_eil_irq_source (.clk_sys_in(clk_sys_in), .assert_in(low),
      .irq_pin_n_out(irq_pin_n));

   initial begin
      forever #2 clk_sys_in = ~clk_sys_in;
   end

   task automatic test_done();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Zero wait states are expected, but the wait is bounded rather than assumed
   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_in);
      req.psel <= 1'b1;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= {24'($urandom()), d};
      @(posedge clk_sys_in);
      req.penable <= 1'b1;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         test_done();
      end
      chk({31'h0, pslverr}, {31'h0, a != EIL_STATUS_CONTROL_ADDR});
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] d);
      apb(1'b1, EIL_STATUS_CONTROL_ADDR, d);
   endtask

   task automatic rd(input logic [7:0] e);
      exp_q.push_back({24'h0, e});
      apb(1'b0, EIL_STATUS_CONTROL_ADDR, 8'h00);
   endtask

   // Pin change plus enough cycles for the synchroniser and latch to settle
   task automatic pin(input logic v);
      @(posedge clk_sys_in);
      low <= v;
      repeat (6) @(posedge clk_sys_in);
   endtask

   task automatic see(input logic v);
      #1;
      chk({31'h0, irq_req}, {31'h0, v});
   endtask

   always @(posedge clk_sys_in) begin
      if (req.psel && req.penable && pready === 1'b1 && !req.pwrite) begin
         if (exp_q.size() == 0) begin
            chk(prdata, 32'hFFFF_FFFF);
         end else begin
            chk(prdata, exp_q.pop_front());
         end
      end
   end

   initial begin
      repeat (5000) @(posedge clk_sys_in);
      miscompares++;
      test_done();
   end

   initial begin
      void'($urandom(33));
      repeat (5) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      rd(8'h00);
      exp_q.push_back(32'h0);
      apb(1'b0, 16'h0010, 8'h00);
      wr(8'hF7);
      rd(8'h03);
      wr(8'h00);
      pin(1'b1);
      see(1'b1);
      rd(8'h08);
      wr(8'h04);
      see(1'b0);
      rd(8'h00);
      pin(1'b0);
      pin(1'b1);
      see(1'b1);
      // Vector fetch from the CPU side
      @(posedge clk_sys_in);
      vfetch <= 1'b1;
      @(posedge clk_sys_in);
      vfetch <= 1'b0;
      #1;
      chk({31'h0, vack}, 32'h1);
      see(1'b0);
      @(posedge clk_sys_in);
      #1;
      chk({31'h0, vack}, 32'h0);
      pin(1'b0);
      wr(8'h02);
      pin(1'b1);
      see(1'b0);
      rd(8'h0A);
      // Level mode must be in force before the acknowledge arrives
      wr(8'h01);
      see(1'b1);
      wr(8'h05);
      see(1'b1);
      rd(8'h09);
      pin(1'b0);
      see(1'b0);
      rd(8'h01);
      pin(1'b1);
      pin(1'b0);
      see(1'b1);
      wr(8'h05);
      see(1'b0);
      wr(8'h00);
      pin(1'b1);
      @(posedge clk_sys_in);
      brk <= 1'b1;
      wr(8'h04);
      see(1'b1);
      @(posedge clk_sys_in);
      bce <= 1'b1;
      wr(8'h04);
      see(1'b0);
      @(posedge clk_sys_in);
      brk <= 1'b0;
      bce <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      see(1'b0);
      // Reset in mid-run with the pin held low in level mode
      wr(8'h01);
      pin(1'b0);
      pin(1'b1);
      see(1'b1);
      @(posedge clk_sys_in);
      reset_n_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      reset_n_in <= 1'b1;
      @(posedge clk_sys_in);
      see(1'b0);
      repeat (6) @(posedge clk_sys_in);
      see(1'b0);
      rd(8'h00);
      pin(1'b0);
      test_done();
   end
endmodule
`default_nettype wire
